//--- src/gpf_port.sv
module gpf_port
    import gpf_pkg::*;
#(
    parameter int ADR_W = 10
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Wishbone classic slave
    input  wire logic             i_wb_cyc,
    input  wire logic             i_wb_stb,
    input  wire logic             i_wb_we,
    input  wire logic [ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]       i_wb_sel,
    input  wire logic [31:0]      i_wb_dat,
    output logic      [31:0]      o_wb_dat,
    output logic                  o_wb_ack,
    // Alternate function sources from the rest of the receiver
    input  wire gpf_alt_t         i_alt,
    // General-purpose pads
    input  wire logic [7:0]       i_pad_in,
    output gpf_pad_t              o_pad,
    // Antenna control input taken from pin 0
    output logic                  o_antenna_link_input,
    output logic                  o_ant_two_pin_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    function automatic logic hits(input logic [ADR_W-1:0] adr,
                                  input logic [7:0]       idx);
        hits = (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
    endfunction : hits

    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic        req;
    logic        wr_lane0;

    // One request per bus cycle: the ack cycle itself takes nothing new
    assign req      = i_wb_cyc && i_wb_stb && !ack_reg;
    // Write lands on the edge where the master sees ack, not before
    assign wr_lane0 = i_wb_cyc && i_wb_stb && ack_reg
                      && i_wb_we && i_wb_sel[0];

    ////////////////////////////////////////////////////////////////////////
    // Writable registers

    logic [7:0] wreg_q [NUM_WREGS];

    genvar g;
    generate
        for (g = 0; g < NUM_WREGS; g++)
        begin : g_wreg
            gpf_byte_reg #(
                .RST   (WREG_RST[g]),
                .WMASK (WREG_WMASK[g])
            ) u_reg (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .i_we    (wr_lane0 && hits(i_wb_adr, WREG_IDX[g])),
                .i_wdata (i_wb_dat[7:0]),
                .o_q     (wreg_q[g])
            );
        end
    endgenerate

    logic [7:0] alt_select;
    logic [7:0] out_levels;
    logic [7:0] out_enable_n;
    logic [7:0] ant_ctrl;
    logic       pin7_alt_select;
    logic       pin6_pin5_alt_select;
    logic       two_pin_mode;

    assign alt_select           = wreg_q[WREG_ALT];
    assign out_levels           = wreg_q[WREG_OUT];
    assign out_enable_n         = wreg_q[WREG_OE];
    assign ant_ctrl             = wreg_q[WREG_ANT];
    assign pin7_alt_select      = alt_select[BIT_PIN7_ALT_SELECT];
    assign pin6_pin5_alt_select = alt_select[BIT_PIN6_PIN5_ALT_SEL];
    assign two_pin_mode         = ant_ctrl[BIT_ANT_TWO_PIN_MODE];

    ////////////////////////////////////////////////////////////////////////
    // Pin input capture

    logic [7:0] in_levels_reg;
    logic [7:0] in_levels_next;

    // Reserved pin 1 reads as zero
    always_comb
    begin
        in_levels_next = i_pad_in & GPIO_PIN_MASK;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            in_levels_reg <= RST_IN_LEVELS;
        end
        else
        begin
            in_levels_reg <= in_levels_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer

    always_comb
    begin
        ack_next  = req;
        rdat_next = rdat_reg;
        if (req && !i_wb_we)
        begin
            if (hits(i_wb_adr, IDX_ALT_SELECT))
            begin
                rdat_next = {24'h00_0000, alt_select};
            end
            else if (hits(i_wb_adr, IDX_OUT_LEVELS))
            begin
                rdat_next = {24'h00_0000, out_levels};
            end
            else if (hits(i_wb_adr, IDX_OUT_ENABLE))
            begin
                rdat_next = {24'h00_0000, out_enable_n};
            end
            else if (hits(i_wb_adr, IDX_IN_LEVELS))
            begin
                rdat_next = {24'h00_0000, in_levels_reg};
            end
            else if (hits(i_wb_adr, IDX_ANT_CTRL))
            begin
                rdat_next = {24'h00_0000, ant_ctrl};
            end
            else
            begin
                rdat_next = RD_UNMAPPED;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ack_reg  <= 1'b0;
            rdat_reg <= RD_UNMAPPED;
        end
        else
        begin
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pad steering

    gpf_pad_t pad_reg;
    gpf_pad_t pad_next;
    logic     ant_in_reg;
    logic     ant_in_next;
    logic     two_pin_reg;

    always_comb
    begin
        // Plain GPIO first; enable is active low in the register
        pad_next.level = out_levels & GPIO_PIN_MASK;
        pad_next.oe    = ~out_enable_n & GPIO_PIN_MASK;

        // Alternate uses override the GPIO settings below
        if (pin7_alt_select)
        begin
            pad_next.level[PIN_HOST_IRQ] = i_alt.host_interrupt_request;
            pad_next.oe[PIN_HOST_IRQ]    = 1'b1;
        end

        if (pin6_pin5_alt_select)
        begin
            pad_next.level[PIN_FRAME_SYNC]   = i_alt.frame_sync_output;
            pad_next.oe[PIN_FRAME_SYNC]      = 1'b1;
            // Reserved pin is left undriven rather than guessing a level
            pad_next.level[PIN_RESERVED_ALT] = 1'b0;
            pad_next.oe[PIN_RESERVED_ALT]    = 1'b0;
        end

        // Pin 1 belongs to the antenna link only
        if (!two_pin_mode)
        begin
            pad_next.level[PIN_ANT_DIRECTION] = i_alt.ant_device_drives;
            pad_next.oe[PIN_ANT_DIRECTION]    = 1'b1;
        end

        if (two_pin_mode)
        begin
            pad_next.level[PIN_ANT_INPUT] = 1'b0;
            pad_next.oe[PIN_ANT_INPUT]    = 1'b0;
        end

        // Input forwarded only in 2-pin mode, held low otherwise
        ant_in_next = two_pin_mode & i_pad_in[PIN_ANT_INPUT];
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            pad_reg     <= '{level: 8'h00, oe: 8'h00};
            ant_in_reg  <= 1'b0;
            two_pin_reg <= 1'b0;
        end
        else
        begin
            pad_reg     <= pad_next;
            ant_in_reg  <= ant_in_next;
            two_pin_reg <= two_pin_mode;
        end
    end

    assign o_pad                = pad_reg;
    assign o_antenna_link_input = ant_in_reg;
    assign o_ant_two_pin_mode   = two_pin_reg;

endmodule : gpf_port

//--- src/gpf_pkg.sv
package gpf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_ALT_SELECT = 8'h4F;
    localparam logic [7:0] IDX_OUT_LEVELS = 8'h50;
    localparam logic [7:0] IDX_OUT_ENABLE = 8'h51;
    localparam logic [7:0] IDX_IN_LEVELS  = 8'h52;
    localparam logic [7:0] IDX_ANT_CTRL   = 8'h5F;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and writable-bit masks
    localparam logic [7:0] RST_ALT_SELECT  = 8'h00;
    localparam logic [7:0] RST_OUT_LEVELS  = 8'h00;
    localparam logic [7:0] RST_OUT_ENABLE  = 8'hFF;
    localparam logic [7:0] RST_ANT_CTRL    = 8'h00;
    localparam logic [7:0] RST_IN_LEVELS   = 8'h00;
    localparam logic [7:0] WMASK_ALT       = 8'hC0;
    localparam logic [7:0] WMASK_OUT       = 8'hFF;
    localparam logic [7:0] WMASK_OE        = 8'hFF;
    localparam logic [7:0] WMASK_ANT       = 8'h01;
    localparam logic [7:0] GPIO_PIN_MASK   = 8'hFD;
    localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and pin numbers
    localparam int BIT_PIN7_ALT_SELECT    = 7;
    localparam int BIT_PIN6_PIN5_ALT_SEL  = 6;
    localparam int BIT_ANT_TWO_PIN_MODE   = 0;
    localparam int PIN_HOST_IRQ           = 7;
    localparam int PIN_RESERVED_ALT       = 6;
    localparam int PIN_FRAME_SYNC         = 5;
    localparam int PIN_ANT_DIRECTION      = 1;
    localparam int PIN_ANT_INPUT          = 0;

    ////////////////////////////////////////////////////////////////////////
    // Writable register bank, built by a generate loop
    localparam int NUM_WREGS = 4;
    localparam int WREG_ALT  = 0;
    localparam int WREG_OUT  = 1;
    localparam int WREG_OE   = 2;
    localparam int WREG_ANT  = 3;
    localparam logic [7:0] WREG_IDX   [NUM_WREGS] =
        '{IDX_ALT_SELECT, IDX_OUT_LEVELS, IDX_OUT_ENABLE, IDX_ANT_CTRL};
    localparam logic [7:0] WREG_RST   [NUM_WREGS] =
        '{RST_ALT_SELECT, RST_OUT_LEVELS, RST_OUT_ENABLE, RST_ANT_CTRL};
    localparam logic [7:0] WREG_WMASK [NUM_WREGS] =
        '{WMASK_ALT, WMASK_OUT, WMASK_OE, WMASK_ANT};

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe;
    } gpf_pad_t;

    typedef struct packed {
        logic host_interrupt_request;
        logic frame_sync_output;
        logic ant_device_drives;
    } gpf_alt_t;

endpackage : gpf_pkg

//--- src/gpf_byte_reg.sv
module gpf_byte_reg
    import gpf_pkg::*;
#(
    parameter logic [7:0] RST   = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
)(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_q
);

    logic [7:0] q_reg;
    logic [7:0] q_next;

    // Bits outside the mask keep their reset value and read back as such
    always_comb
    begin
        q_next = q_reg;
        if (i_we)
        begin
            q_next = (i_wdata & WMASK) | (RST & ~WMASK);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            q_reg <= RST;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;

endmodule : gpf_byte_reg

//--- test/gpf_board.sv
module gpf_board
    import gpf_pkg::*;
(
    input  wire gpf_pad_t   i_pad,
    input  wire logic [7:0] i_ext,
    output logic      [7:0] o_pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board drives a pin only where the block leaves it undriven
    assign o_pad_in = (i_pad.level & i_pad.oe) | (i_ext & ~i_pad.oe);
endmodule : gpf_board

//--- test/gpf_port_sva.sv
module gpf_port_sva
    import gpf_pkg::*;
#(
    parameter int ADR_W = 10
)(
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire logic             i_wb_cyc,
    input wire logic             i_wb_stb,
    input wire logic             i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [31:0]      o_wb_dat,
    input wire logic             o_wb_ack,
    input wire gpf_alt_t         i_alt,
    input wire logic [7:0]       i_pad_in,
    input wire gpf_pad_t         o_pad,
    input wire logic             o_antenna_link_input,
    input wire logic             o_ant_two_pin_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic       req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire logic       two = o_ant_two_pin_mode;
    wire logic [7:0] idx = i_wb_adr[ADR_W-1:2];
    ////////////////////////////////////////////////////////////////////////
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack wider than one cycle");
    ack_answer_a: assert property (req |=> o_wb_ack)
        else $error("request not answered next cycle");
    ack_cause_a: assert property (o_wb_ack |-> $past(req))
        else $error("ack without request");
    // Mode must be steady two cycles; its flop loads on the same edge as the pads
    one_pin_a: assert property (
        $past(i_rst_n) && !two && !$past(two) |->
        o_pad.oe[1] && o_pad.level[1] == $past(i_alt.ant_device_drives))
        else $error("pin 1 not showing antenna direction");
    two_pin_a: assert property (
        $past(i_rst_n) && two && $past(two) |-> o_pad.oe[1:0] == 2'h0)
        else $error("pins 1..0 driven in two pin mode");
    ant_in_a: assert property (
        $past(i_rst_n) && two == $past(two) |->
        o_antenna_link_input == (two & $past(i_pad_in[0])))
        else $error("antenna input not following pin 0");
    in_read_a: assert property (
        o_wb_ack && $past(!i_wb_we && idx == IDX_IN_LEVELS)
        && $past(i_rst_n, 2) |->
        o_wb_dat[7:0] == ($past(i_pad_in, 2) & GPIO_PIN_MASK))
        else $error("input levels read wrong");
    alt_read_a: assert property (
        o_wb_ack && $past(!i_wb_we && idx == IDX_ALT_SELECT) |->
        o_wb_dat[5:0] == 6'h00)
        else $error("reserved select bits not zero");
    wr_c: cover property (req && i_wb_we);
    two_c: cover property (two && o_antenna_link_input);
    irq_c: cover property (o_pad.oe[7] && o_pad.level[7]);
endmodule : gpf_port_sva

bind gpf_port gpf_port_sva #(.ADR_W(ADR_W)) u_gpf_port_sva (.*);

//--- test/gpf_port_tb.sv
module gpf_port_tb import gpf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    gpf_alt_t    alt = '0;
    logic [7:0]  ext = 8'h00;
    logic [7:0]  pad_in;
    gpf_pad_t    pad;
    logic        ant_in;
    logic        two_pin;
    logic [7:0]  q;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #4 clk = ~clk;
    gpf_port #(.ADR_W(10)) u_gpf_port (.i_clk(clk), .i_rst_n(rst_n),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_alt(alt), .i_pad_in(pad_in), .o_pad(pad),
        .o_antenna_link_input(ant_in), .o_ant_two_pin_mode(two_pin));
    gpf_board u_gpf_board (.i_pad(pad), .i_ext(ext), .o_pad_in(pad_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] i, d, input logic s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= {3'b000, s};
        dat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] i);
        wb(1'b0, i, 8'h00, 1'b1);
    endtask : rd
    task automatic tick;
        repeat (3) @(posedge clk);
    endtask : tick
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(IDX_ALT_SELECT);
        check(q, 8'h00);
        rd(IDX_OUT_LEVELS);
        check(q, 8'h00);
        rd(IDX_OUT_ENABLE);
        check(q, 8'hFF);
        rd(8'h7E);
        check(q, 8'h00);
        check(pad.oe, 8'h02);
    endtask : t_reset
    task automatic t_gpio;
        wb(1'b1, IDX_OUT_ENABLE, 8'h00, 1'b1);
        wb(1'b1, IDX_OUT_LEVELS, 8'hFF, 1'b1);
        wb(1'b1, IDX_OUT_LEVELS, 8'h00, 1'b0);
        tick;
        check(pad, 16'hFDFF);
        rd(IDX_OUT_LEVELS);
        check(q, 8'hFF);
        rd(IDX_OUT_ENABLE);
        check(q, 8'h00);
        alt <= 3'b001;
        tick;
        check(pad.level[1], 1'b1);
    endtask : t_gpio
    task automatic t_alt;
        wb(1'b1, IDX_ALT_SELECT, 8'hFF, 1'b1);
        rd(IDX_ALT_SELECT);
        check(q, 8'hC0);
        alt <= 3'b101;
        tick;
        check(pad.oe, 8'hBF);
        check(pad.level & 8'hA0, 8'h80);
        alt <= 3'b011;
        tick;
        check(pad.level & 8'hA0, 8'h20);
    endtask : t_alt
    task automatic t_input;
        wb(1'b1, IDX_ALT_SELECT, 8'h00, 1'b1);
        wb(1'b1, IDX_OUT_ENABLE, 8'hFF, 1'b1);
        ext <= 8'h5A;
        tick;
        rd(IDX_IN_LEVELS);
        check(q, 8'h58);
        wb(1'b1, IDX_IN_LEVELS, 8'h00, 1'b1);
        rd(IDX_IN_LEVELS);
        check(q, 8'h58);
    endtask : t_input
    task automatic t_two_pin;
        wb(1'b1, IDX_OUT_ENABLE, 8'h00, 1'b1);
        wb(1'b1, IDX_ANT_CTRL, 8'hFF, 1'b1);
        rd(IDX_ANT_CTRL);
        check(q, 8'h01);
        ext <= 8'h5B;
        tick;
        check(two_pin, 1'b1);
        check(pad.oe[1:0], 2'h0);
        check(ant_in, 1'b1);
        ext <= 8'h5A;
        tick;
        check(ant_in, 1'b0);
    endtask : t_two_pin
    // Reset in mid-run must drop two-pin mode and every setting
    task automatic t_rerun;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
    endtask : t_rerun
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // Whole run needs about a hundred cycles; ceiling of 3000 leaves wide margin
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_gpio;
        t_alt;
        t_input;
        t_two_pin;
        t_rerun;
        report_and_stop;
    end
endmodule : gpf_port_tb
